// ### src/xbpi_top.sv
`timescale 1ns/1ps
// Operation
// - Four active-low byte strobes, first is MSB
// - Active-low output enable lets memory drive
// - Six chip selects; two shared, SDRAM default
// - Burst restart input forces a new address latch, keeping the current address and remaining beats
// - Active-low address latch marks burst start
// - Burst clock runs during burst mode
// - Direction high read, low write
// - Bus error after 1022 clocks without acknowledge
// - Boot mode sampled from pins at reset
// - Second SDRAM select serves as boot select
// - Bank bits 25:21 on address pins 15:11
// - Interleave bank 12:9 on pins 19:16
// - SDRAM row/column low bits on pins 10:1
// - Dedicated upper address, data masks, strobes
module xbpi_top
    import xbpi_pkg::*;
#(
    parameter int LIMIT = ACK_TIMEOUT,
    parameter int HALF = BCLK_HALF
) (
    input wire logic clk,
    input wire logic rst,
    // Core request side
    input wire logic req_valid,
    input wire logic req_write,
    input wire xbpi_pkg::xbpi_kind_type req_kind,
    input wire xbpi_pkg::xbpi_size_type req_size,
    input wire logic [2:0] req_cs,
    input wire logic [xbpi_pkg::CORE_ADDR_W-1:0] req_addr,
    input wire logic [xbpi_pkg::DATA_W-1:0] req_wdata,
    input wire logic [3:0] req_beats,
    input wire logic use_ext_ack,
    input wire logic [1:0] function_mux_control,
    input wire logic [1:0] sdram_cmd,
    output logic req_ready,
    output logic resp_valid,
    output logic resp_bus_error,
    output logic [xbpi_pkg::DATA_W-1:0] resp_rdata,
    output logic [xbpi_pkg::BOOT_W-1:0] boot_mode,
    output logic boot_sflash,
    // Pins
    output logic [xbpi_pkg::ADDR_W-1:0] addr_pin,
    input wire logic [xbpi_pkg::DATA_W-1:0] data_in,
    output logic [xbpi_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic [xbpi_pkg::LANES-1:0] byte_lane_strobe_n,
    output logic output_enable_n,
    output logic [xbpi_pkg::CS_N-1:0] chip_select_n,
    output logic [1:0] sdram_chip_select_n,
    input wire logic burst_restart_n,
    output logic burst_addr_latch_n,
    output logic burst_clk,
    output logic read_write,
    input wire logic transfer_ack_n,
    input wire logic [xbpi_pkg::BOOT_W-1:0] boot_pins,
    output logic [xbpi_pkg::MA_HIGH_W-1:0] mem_row_col_addr_hi,
    output logic [xbpi_pkg::LANES-1:0] dqm,
    output logic ras_n,
    output logic cas_n,
    output logic sdram_we_n
);
    import xbpi_pkg::*;

    typedef enum {ST_IDLE, ST_LATCH, ST_WAIT, ST_DONE} xbpi_state_type;

    // Lane enables, bit 3 = MSB lane (data[31:24])
    function automatic logic [LANES-1:0] lane_mask(input xbpi_size_type sz, input logic [1:0] a);
        logic [LANES-1:0] m;
        m = 4'h0;
        case (sz)
            XBPI_BYTE: m = 4'h8 >> a;
            XBPI_HALF: m = a[1] ? 4'h3 : 4'hc;
            default: m = 4'hf;
        endcase
        return m;
    endfunction : lane_mask

    logic ack_s;
    logic restart_s;
    logic [BOOT_W-1:0] boot_s;
    logic expired;
    logic [3:0] sync_out;

    // Pins from outside the clock domain
    xbpi_sync #(.W(2), .INIT(2'h3)) u_sync_ctl (
        .clk(clk),
        .rst(rst),
        .din({transfer_ack_n, burst_restart_n}),
        .dout(sync_out[1:0])
    );
    // Boot pins keep sampling through reset so the captured mode is the pin level, not INIT
    xbpi_sync #(.W(BOOT_W), .INIT(BOOT_RESET)) u_sync_boot (
        .clk(clk),
        .rst(1'b0),
        .din(boot_pins),
        .dout(boot_s)
    );
    assign ack_s = ~sync_out[1];
    assign restart_s = ~sync_out[0];
    assign sync_out[3:2] = 2'h0;

    xbpi_state_type st_q, st_d;
    xbpi_kind_type kind_q, kind_d;
    logic write_q, write_d;
    logic [CORE_ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [LANES-1:0] lanes_q, lanes_d;
    logic [2:0] cs_q, cs_d;
    logic [3:0] beats_q, beats_d;
    logic [1:0] cmd_q, cmd_d;
    logic ext_q, ext_d;
    logic [2:0] bdiv_q, bdiv_d;
    logic bclk_q, bclk_d;
    logic boot_hold_q, boot_hold_d;
    logic [BOOT_W-1:0] boot_q, boot_d;
    logic [1:0] fmux_q, fmux_d;
    logic waiting;

    // Output register next values
    logic ready_d, rv_d, berr_d, latch_n_d, oe_n_d, doe_d, rw_d;
    logic [DATA_W-1:0] rdata_d, dout_d;
    logic [ADDR_W-1:0] apin_d;
    logic [LANES-1:0] strobe_n_d, dqm_d;
    logic [CS_N-1:0] cs_n_d;
    logic [1:0] csd_n_d;
    logic [1:0] mahi_d;
    logic ras_n_d, cas_n_d, swe_n_d;

    assign waiting = (st_q == ST_WAIT) && ext_q;

    // Time-out only runs while an externally acknowledged cycle waits
    xbpi_timeout #(.LIMIT(LIMIT)) u_tmo (
        .clk(clk),
        .rst(rst),
        .run(waiting),
        .expired(expired)
    );

    // Cycle sequencer
    always_comb
    begin
        st_d = st_q;
        kind_d = kind_q;
        write_d = write_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        lanes_d = lanes_q;
        cs_d = cs_q;
        beats_d = beats_q;
        cmd_d = cmd_q;
        ext_d = ext_q;
        rv_d = 1'b0;
        berr_d = 1'b0;
        rdata_d = resp_rdata;
        case (st_q)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    kind_d = req_kind;
                    write_d = req_write;
                    addr_d = req_addr;
                    wdata_d = req_wdata;
                    lanes_d = lane_mask(req_size, req_addr[1:0]);
                    cs_d = req_cs;
                    beats_d = req_beats;
                    cmd_d = req_sdram_cmd_fix(sdram_cmd);
                    ext_d = use_ext_ack;
                    st_d = (req_kind == XBPI_BURST) ? ST_LATCH : ST_WAIT;
                end
            end
            ST_LATCH:
                st_d = ST_WAIT;
            ST_WAIT:
            begin
                if (kind_q == XBPI_BURST && restart_s)
                begin
                    st_d = ST_LATCH;
                end
                else if (expired)
                begin
                    berr_d = 1'b1;
                    rv_d = 1'b1;
                    st_d = ST_DONE;
                end
                else if (ack_s || !ext_q)
                begin
                    rdata_d = data_in;
                    rv_d = 1'b1;
                    if (kind_q == XBPI_BURST && beats_q != 4'h0)
                    begin
                        beats_d = beats_q - 1'b1;
                        addr_d = addr_q + CORE_ADDR_W'(LANES);
                    end
                    else
                    begin
                        st_d = ST_DONE;
                    end
                end
            end
            ST_DONE:
                st_d = ack_s ? ST_DONE : ST_IDLE; // Wait for ack release
            default:
                st_d = ST_IDLE;
        endcase
    end

    function automatic logic [1:0] req_sdram_cmd_fix(input logic [1:0] c);
        return c;
    endfunction : req_sdram_cmd_fix

    // Boot pins captured once after reset release; function mux defaults to SDRAM selects
    always_comb
    begin
        boot_hold_d = 1'b1;
        boot_d = boot_hold_q ? boot_q : boot_s;
        fmux_d = boot_hold_q ? function_mux_control : FMUX_RESET;
    end

    // Burst clock from a divider, only while a burst runs
    always_comb
    begin
        bdiv_d = 3'h0;
        bclk_d = 1'b0;
        if (kind_q == XBPI_BURST && (st_q == ST_WAIT || st_q == ST_LATCH))
        begin
            bdiv_d = (bdiv_q == 3'(HALF - 1)) ? 3'h0 : bdiv_q + 1'b1;
            bclk_d = (bdiv_q == 3'(HALF - 1)) ? ~bclk_q : bclk_q;
        end
    end

    // Pin drive
    always_comb
    begin
        logic act;
        logic sd;
        // Pins follow the next state so they are live in the cycle that samples data_in
        act = (st_d == ST_LATCH) || (st_d == ST_WAIT);
        sd = (kind_d == XBPI_SDRAM) || (kind_d == XBPI_SDRAM_IL);
        ready_d = (st_d == ST_IDLE);
        latch_n_d = ~(st_d == ST_LATCH);
        rw_d = ~(act && write_d);
        oe_n_d = ~(act && !write_d && !sd);
        doe_d = act && write_d;
        dout_d = wdata_d;
        strobe_n_d = (act && !sd) ? ~lanes_d : 4'hf;
        dqm_d = (act && sd) ? ~lanes_d : 4'hf;
        cs_n_d = 6'h3f;
        csd_n_d = 2'h3;
        apin_d = addr_d[ADDR_W-1:0];
        mahi_d = 2'h0;
        ras_n_d = 1'b1;
        cas_n_d = 1'b1;
        swe_n_d = 1'b1;
        if (act)
        begin
            if (sd)
            begin
                if (cs_d == 3'(CSD_FIRST) || cs_d == 3'(CSD_FIRST + 1))
                    csd_n_d[cs_d[0]] = ~fmux_q[cs_d[0]];
                apin_d[MA_LOW_PIN_LO +: MA_LOW_W] = addr_d[MA_LOW_PIN_LO +: MA_LOW_W];
                mahi_d = addr_d[MA_LOW_PIN_LO + MA_LOW_W +: MA_HIGH_W];
                if (kind_d == XBPI_SDRAM)
                    apin_d[BANK_PIN_LO +: BANK_W] = addr_d[BANK_CORE_LO +: BANK_W];
                else
                    apin_d[IBANK_PIN_LO +: IBANK_W] = addr_d[IBANK_CORE_LO +: IBANK_W];
                ras_n_d = ~cmd_d[1];
                cas_n_d = ~cmd_d[0];
                swe_n_d = ~write_d;
            end
            else if (cs_d < 3'(CS_N))
            begin
                // Shared pins only reach the static select when the mux picks it
                if (!(cs_d == 3'(CSD_FIRST) && fmux_q[0]) && !(cs_d == 3'(CSD_FIRST + 1) && fmux_q[1]))
                    cs_n_d[cs_d] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            kind_q <= XBPI_ASYNC;
            write_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            lanes_q <= '0;
            cs_q <= '0;
            beats_q <= '0;
            cmd_q <= '0;
            ext_q <= 1'b0;
            bdiv_q <= '0;
            bclk_q <= 1'b0;
            boot_hold_q <= 1'b0;
            boot_q <= BOOT_RESET;
            fmux_q <= FMUX_RESET;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_bus_error <= 1'b0;
            resp_rdata <= '0;
            addr_pin <= '0;
            data_out <= '0;
            data_oe <= 1'b0;
            byte_lane_strobe_n <= 4'hf;
            output_enable_n <= 1'b1;
            chip_select_n <= 6'h3f;
            sdram_chip_select_n <= 2'h3;
            burst_addr_latch_n <= 1'b1;
            read_write <= 1'b1;
            mem_row_col_addr_hi <= '0;
            dqm <= 4'hf;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            sdram_we_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            kind_q <= kind_d;
            write_q <= write_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            lanes_q <= lanes_d;
            cs_q <= cs_d;
            beats_q <= beats_d;
            cmd_q <= cmd_d;
            ext_q <= ext_d;
            bdiv_q <= bdiv_d;
            bclk_q <= bclk_d;
            boot_hold_q <= boot_hold_d;
            boot_q <= boot_d;
            fmux_q <= fmux_d;
            req_ready <= ready_d;
            resp_valid <= rv_d;
            resp_bus_error <= berr_d;
            resp_rdata <= rdata_d;
            addr_pin <= apin_d;
            data_out <= dout_d;
            data_oe <= doe_d;
            byte_lane_strobe_n <= strobe_n_d;
            output_enable_n <= oe_n_d;
            chip_select_n <= cs_n_d;
            sdram_chip_select_n <= csd_n_d;
            burst_addr_latch_n <= latch_n_d;
            read_write <= rw_d;
            mem_row_col_addr_hi <= mahi_d;
            dqm <= dqm_d;
            ras_n <= ras_n_d;
            cas_n <= cas_n_d;
            sdram_we_n <= swe_n_d;
        end
    end

    assign burst_clk = bclk_q;
    assign boot_mode = boot_q;
    // Default mux leaves second SDRAM select on the boot pin
    assign boot_sflash = (boot_q == BOOT_SFLASH) && fmux_q[1];
endmodule : xbpi_top

// ### src/xbpi_pkg.sv
package xbpi_pkg;
    // Pin widths and core address width
    localparam int ADDR_W = 25;
    localparam int CORE_ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int CS_N = 6;
    localparam int BOOT_W = 4;
    // Shared-pin positions for SDRAM addressing
    localparam int BANK_PIN_LO = 11;
    localparam int BANK_CORE_LO = 21;
    localparam int BANK_W = 5;
    localparam int IBANK_PIN_LO = 16;
    localparam int IBANK_CORE_LO = 9;
    localparam int IBANK_W = 4;
    localparam int MA_LOW_PIN_LO = 1;
    localparam int MA_LOW_W = 10;
    localparam int MA_HIGH_W = 2;
    localparam int CSD_FIRST = 2;
    // Time-out in clock counts
    localparam int ACK_TIMEOUT = 1022;
    localparam int TMO_W = 10;
    // Burst clock divide: half period in system clocks
    localparam int BCLK_HALF = 2;
    // Reset values and the serial-flash boot code
    localparam logic [1:0] FMUX_RESET = 2'h3;
    localparam logic [BOOT_W-1:0] BOOT_RESET = 4'h0;
    localparam logic [BOOT_W-1:0] BOOT_SFLASH = 4'h3;
    // Access size codes
    typedef enum logic [1:0] {XBPI_BYTE, XBPI_HALF, XBPI_WORD, XBPI_RSVD} xbpi_size_type;
    // Cycle kinds
    typedef enum logic [1:0] {XBPI_ASYNC, XBPI_BURST, XBPI_SDRAM, XBPI_SDRAM_IL} xbpi_kind_type;
endpackage : xbpi_pkg

// ### src/xbpi_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module xbpi_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    // Only the second stage is visible outside
    always_comb
    begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= INIT;
            dout <= INIT;
        end
        else
        begin
            meta_q <= meta_d;
            dout <= sync_d;
        end
    end
endmodule : xbpi_sync

// ### src/xbpi_timeout.sv
`timescale 1ns/1ps
// Bus time-out monitor: counts clocks while a cycle waits for acknowledge
module xbpi_timeout
    import xbpi_pkg::*;
#(
    parameter int LIMIT = ACK_TIMEOUT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic expired
);
    logic [TMO_W-1:0] cnt_q;
    logic [TMO_W-1:0] cnt_d;
    logic expired_d;

    // Counter restarts whenever no cycle is waiting
    always_comb
    begin
        cnt_d = '0;
        expired_d = 1'b0;
        if (run)
        begin
            if (cnt_q == TMO_W'(LIMIT - 1))
            begin
                expired_d = 1'b1;
                cnt_d = cnt_q;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            expired <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            expired <= expired_d;
        end
    end
endmodule : xbpi_timeout

// ### tb/xbpi_monitor.sv
`timescale 1ns/1ps
// Pin-level checks on the external bus, bound to the top module
module xbpi_monitor
    import xbpi_pkg::*;
#(
    parameter int LIMIT = ACK_TIMEOUT,
    parameter int HALF = BCLK_HALF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic resp_bus_error,
    input wire logic use_ext_ack,
    input wire logic data_oe,
    input wire logic [xbpi_pkg::LANES-1:0] byte_lane_strobe_n,
    input wire logic output_enable_n,
    input wire logic [xbpi_pkg::CS_N-1:0] chip_select_n,
    input wire logic [1:0] sdram_chip_select_n,
    input wire logic burst_addr_latch_n,
    input wire logic burst_clk,
    input wire logic read_write
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Latch is one low cycle; a longer pulse would swallow the first burst clock
    sequence latch_pulse;
        !burst_addr_latch_n ##1 burst_addr_latch_n;
    endsequence
    sequence idle_twice;
        req_ready ##1 req_ready;
    endsequence
    // Pin relations
    chk_idle_pins_high: assert property (req_ready |-> byte_lane_strobe_n == '1 && chip_select_n == '1)
        else $error("strobe or select active while idle");
    chk_oe_on_read: assert property (!output_enable_n |-> read_write && !data_oe)
        else $error("output enable outside a read");
    chk_write_dir: assert property (data_oe |-> !read_write)
        else $error("data driven while direction says read");
    chk_err_with_resp: assert property (resp_bus_error |-> resp_valid && use_ext_ack)
        else $error("bus error without response or external ack");
    chk_latch_single: assert property ($fell(burst_addr_latch_n) |-> latch_pulse)
        else $error("address latch pulse not one cycle");
    chk_select_onehot: assert property ($onehot0(~chip_select_n))
        else $error("more than one chip select active");
    chk_sdram_no_strobe: assert property (sdram_chip_select_n != 2'h3 |-> byte_lane_strobe_n == '1)
        else $error("byte strobes active in a memory array cycle");
    chk_bclk_still: assert property (idle_twice |-> $stable(burst_clk))
        else $error("burst clock moving while idle");
endmodule : xbpi_monitor

bind xbpi_top xbpi_monitor #(.LIMIT(LIMIT), .HALF(HALF)) u_monitor (.clk, .rst, .req_ready, .resp_valid,
    .resp_bus_error, .use_ext_ack, .data_oe, .byte_lane_strobe_n, .output_enable_n, .chip_select_n,
    .sdram_chip_select_n, .burst_addr_latch_n, .burst_clk, .read_write);

// ### tb/xbpi_mem_model.sv
`timescale 1ns/1ps
// Static and burst memory on the far side of the pins
module xbpi_mem_model (
    input wire logic clk,
    input wire logic lclk,
    input wire logic [24:0] addr_pin,
    input wire logic [31:0] data_out,
    input wire logic data_oe,
    input wire logic [3:0] byte_lane_strobe_n,
    input wire logic output_enable_n,
    input wire logic [5:0] chip_select_n,
    input wire logic [3:0] ack_delay,
    input wire logic mute,
    input wire logic restart,
    output logic [31:0] data_in,
    output logic transfer_ack_n = 1'b1,
    output logic burst_restart_n = 1'b1
);
    logic [31:0] mem_q [16];
    logic [31:0] last_q = 32'h0;
    logic [3:0] wait_q = 4'h0;
    wire sel = chip_select_n != 6'h3f;
    // Released bus shows the inverse of its last value, never a stale copy
    assign data_in = output_enable_n ? ~last_q : mem_q[addr_pin[5:2]];
    // Lane i carries bits 8i+7:8i, lane 3 the top byte
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
            if (sel && data_oe && !byte_lane_strobe_n[i])
                mem_q[addr_pin[5:2]][8*i +: 8] <= data_out[8*i +: 8];
        if (!output_enable_n)
            last_q <= data_in;
    end
    // Ack and restart come from the memory's own slow clock
    always @(posedge lclk)
    begin
        wait_q <= sel ? wait_q + 4'h1 : 4'h0;
        transfer_ack_n <= !(sel && !mute && wait_q >= ack_delay);
        burst_restart_n <= !restart;
    end
endmodule : xbpi_mem_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import xbpi_pkg::*;
    localparam int LIM = 40;
    logic clk, lclk, rst, req_valid, req_write, use_ext_ack, burst_restart_n, transfer_ack_n, mute, restart;
    logic req_ready, resp_valid, resp_bus_error, boot_sflash, data_oe, output_enable_n, burst_addr_latch_n;
    logic burst_clk, read_write, ras_n, cas_n, sdram_we_n, o_rw, o_oe, o_err;
    xbpi_kind_type req_kind;
    xbpi_size_type req_size;
    logic [2:0] req_cs, o_rc;
    logic [25:0] req_addr;
    logic [31:0] req_wdata, resp_rdata, data_in, data_out;
    logic [3:0] req_beats, boot_mode, boot_pins, ack_delay, byte_lane_strobe_n, dqm, o_strb, o_dqm;
    logic [1:0] function_mux_control, sdram_cmd, sdram_chip_select_n, mem_row_col_addr_hi, o_sd, o_hi;
    logic [24:0] addr_pin, o_addr;
    logic [5:0] chip_select_n, o_cs;
    logic [31:0] rd [$];
    int n_errors = 0, cmp_count = 0, o_lat, o_bclk, o_cyc, rs_at;
    xbpi_top #(.LIMIT(LIM)) dut (.clk, .rst, .req_valid, .req_write, .req_kind, .req_size, .req_cs, .req_addr,
        .req_wdata, .req_beats, .use_ext_ack, .function_mux_control, .sdram_cmd, .req_ready, .resp_valid,
        .resp_bus_error, .resp_rdata, .boot_mode, .boot_sflash, .addr_pin, .data_in, .data_out, .data_oe,
        .byte_lane_strobe_n, .output_enable_n, .chip_select_n, .sdram_chip_select_n, .burst_restart_n,
        .burst_addr_latch_n, .burst_clk, .read_write, .transfer_ack_n, .boot_pins, .mem_row_col_addr_hi,
        .dqm, .ras_n, .cas_n, .sdram_we_n);
    xbpi_mem_model u_mem (.clk, .lclk, .addr_pin, .data_out, .data_oe, .byte_lane_strobe_n, .output_enable_n,
        .chip_select_n, .ack_delay, .mute, .restart, .data_in, .transfer_ack_n, .burst_restart_n);
    // Clocks: the memory clock is slower and offset in phase
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        lclk = 1'b0;
        #3;
        forever #32 lclk = ~lclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run;
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // One request, then record the pins until all beats or an error return
    task automatic acc(input xbpi_kind_type k, input logic w, input xbpi_size_type s, input logic [2:0] c,
                       input logic [25:0] a, input logic [31:0] d, input logic [3:0] b, input logic x);
        int i, n;
        logic pl, pb;
        n = 0;
        o_lat = 0;
        o_bclk = 0;
        {o_strb, o_cs, o_sd, o_rw, o_oe, o_err} = {4'hf, 6'h3f, 2'h3, 3'h6};
        rd.delete();
        @(negedge clk);
        for (i = 0; i < 60 && req_ready !== 1'b1; i++)
            @(negedge clk);
        @(posedge clk);
        req_kind <= k;
        req_size <= s;
        {req_write, req_cs, req_addr, req_wdata, req_beats, use_ext_ack} <= {w, c, a, d, b, x};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        pl = 1'b1;
        pb = burst_clk;
        for (i = 0; i < 300 && n <= b && !o_err; i++)
        begin
            @(negedge clk);
            restart <= (i >= rs_at && i < rs_at + 10);
            if (chip_select_n != 6'h3f || sdram_chip_select_n != 2'h3)
                {o_strb, o_cs, o_sd, o_addr, o_hi, o_rw, o_dqm, o_rc} = {byte_lane_strobe_n, chip_select_n,
                    sdram_chip_select_n, addr_pin, mem_row_col_addr_hi, read_write, dqm, ras_n, cas_n, sdram_we_n};
            o_oe &= output_enable_n;
            o_lat += int'(pl && !burst_addr_latch_n);
            o_bclk += int'(pb != burst_clk);
            pl = burst_addr_latch_n;
            pb = burst_clk;
            if (resp_valid === 1'b1)
            begin
                rd.push_back(resp_rdata);
                o_err = resp_bus_error;
                n++;
            end
        end
        o_cyc = i;
        restart <= 1'b0;
    endtask : acc
    task automatic t_reset;
        repeat (3) @(negedge clk);
        chk("boot_mode", BOOT_SFLASH, boot_mode);
        chk("boot_sflash", 1, boot_sflash);
        chk("idle_pins", 32'h3ff, {chip_select_n, byte_lane_strobe_n});
        chk("idle_dir", 1, read_write);
    endtask : t_reset
    task automatic t_sdram;
        acc(XBPI_SDRAM, 1'b0, XBPI_WORD, 3'h3, 26'h2b5_3e6c, 32'h0, 4'h0, 1'b0);
        chk("bank", req_addr[25:21], o_addr[15:11]);
        chk("ma_hi", req_addr[12:11], o_hi);
        chk("sd_select", 1, o_sd != 2'h3);
        chk("ma_low", req_addr[10:1], o_addr[10:1]);
        chk("dqm", 0, o_dqm);
        chk("sd_strobes", 3'h1, o_rc);
        acc(XBPI_SDRAM_IL, 1'b0, XBPI_WORD, 3'h3, 26'h1c6_a5b4, 32'h0, 4'h0, 1'b0);
        chk("ibank", req_addr[12:9], o_addr[19:16]);
    endtask : t_sdram
    task automatic t_lanes;
        xbpi_size_type sz [7] = '{XBPI_BYTE, XBPI_BYTE, XBPI_BYTE, XBPI_BYTE, XBPI_HALF, XBPI_HALF, XBPI_WORD};
        logic [3:0] m [7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hc, 4'h3, 4'hf};
        @(posedge clk);
        function_mux_control <= 2'h0;
        for (int j = 0; j < 7; j++)
        begin
            acc(XBPI_ASYNC, 1'b1, sz[j], 3'h0, 26'h40 + 26'(j < 4 ? j : (j - 4) * 2), 32'h5a5a_5a5a, 4'h0, 1'b0);
            chk("lane_strobes", {28'h0, ~m[j]}, o_strb);
            chk("write_dir", 0, o_rw);
        end
    endtask : t_lanes
    task automatic t_burst;
        for (int j = 0; j < 16; j++)
            acc(XBPI_ASYNC, 1'b1, XBPI_WORD, 3'h1, 26'(j * 4), 32'h3c00_0000 + 32'(j * 7), 4'h0, 1'b0);
        acc(XBPI_ASYNC, 1'b0, XBPI_WORD, 3'h1, 26'h8, 32'h0, 4'h0, 1'b0);
        chk("read_data", 32'h3c00_000e, rd[0]);
        chk("read_oe", 0, o_oe);
        chk("read_dir", 1, o_rw);
        acc(XBPI_BURST, 1'b0, XBPI_WORD, 3'h1, 26'h0, 32'h0, 4'hf, 1'b0);
        chk("latches", 1, o_lat);
        chk("burst_clock", 1, o_bclk > 0);
        for (int j = 0; j < 16; j++)
            chk("burst_data", 32'h3c00_0000 + 32'(j * 7), rd[j]);
        rs_at = 2;
        acc(XBPI_BURST, 1'b0, XBPI_WORD, 3'h1, 26'h0, 32'h0, 4'hf, 1'b0);
        rs_at = 999;
        chk("restart_latch", 1, o_lat >= 2);
    endtask : t_burst
    task automatic t_ack;
        for (int j = 0; j < 6; j++)
        begin
            ack_delay <= 4'(j % 3);
            acc(XBPI_ASYNC, 1'b0, XBPI_WORD, 3'(j), 26'h10, 32'h0, 4'h0, 1'b1);
            chk("select", {26'h0, ~(6'h1 << j)}, o_cs);
            chk("ack_data", 32'h3c00_001c, rd[0]);
        end
        mute <= 1'b1;
        acc(XBPI_ASYNC, 1'b0, XBPI_WORD, 3'h5, 26'h0, 32'h0, 4'h0, 1'b1);
        mute <= 1'b0;
        chk("bus_error", 1, o_err);
        chk("timeout_span", 1, o_cyc >= LIM && o_cyc <= LIM + 8);
    endtask : t_ack
    // Main sequence
    initial
    begin
        {rst, req_valid, req_write, use_ext_ack, mute, restart} = 6'h20;
        {req_cs, req_addr, req_wdata, req_beats, ack_delay, rs_at} = {3'h0, 26'h0, 32'h0, 8'h0, 32'd999};
        req_kind = XBPI_ASYNC;
        req_size = XBPI_WORD;
        boot_pins = BOOT_SFLASH;
        function_mux_control = 2'h3;
        sdram_cmd = 2'h3;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_sdram;
        t_lanes;
        t_burst;
        t_ack;
        complete_run;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run;
    end
endmodule : tb
